// ### t1c_pkg.sv
// Constants shared by the timer control block
package t1c_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_IDX = 2'h0;
  localparam logic [ADDR_W-1:0] COUNT_IDX = 2'h1;
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int ESRC_LSB = 8;
  localparam int GATE_BIT = 6;
  localparam int PRE_LSB = 4;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam logic [15:0] CTRL_MASK = 16'ha376;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [1:0] ESRC_SECONDARY_OSC = 2'h0;
  localparam logic [1:0] ESRC_PIN = 2'h1;
  localparam logic [1:0] ESRC_LOW_POWER_RC_OSC = 2'h2;
  localparam logic [1:0] ESRC_RSVD = 2'h3;
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_8 = 2'h1;
  localparam logic [1:0] PRE_SEL_64 = 2'h2;
  localparam logic [1:0] PRE_SEL_256 = 2'h3;
  localparam logic [7:0] PRE_LAST_1 = 8'h00;
  localparam logic [7:0] PRE_LAST_8 = 8'h07;
  localparam logic [7:0] PRE_LAST_64 = 8'h3f;
  localparam logic [7:0] PRE_LAST_256 = 8'hff;
  localparam int NUM_SRC = 3;
  localparam int SRC_SECONDARY_OSC = 0;
  localparam int SRC_PIN = 1;
  localparam int SRC_LOW_POWER_RC_OSC = 2;
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_RUN = 3'b010,
    ST_IDLE = 3'b100
  } t1c_state_t;
endpackage : t1c_pkg

// ### t1c_timer.sv
// Timer control register, clock selection, prescaler and 16-bit count
`timescale 1ns/1ns

// Summary of operation
// - Extended source field used only when source_sel=1
// - Extended codes: 00 secondary_osc, 01 pin, 10 low_power_rc_osc
// - Internal clock plus gate bit gives gated accumulation
// - Gate bit ignored with extended source selected
// - Prescale 11/256, 10/64, 01/8, 00/1
module t1c_timer
  import t1c_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic idle_i,
  input wire logic ext_count_pin_i,
  input wire logic low_power_rc_osc_i,
  input wire logic secondary_osc_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic [DATA_W-1:0] count_o,
  output logic running_o
);

  logic [15:0] ctrl;
  logic [15:0] count;
  logic [7:0] pre_cnt;
  t1c_state_t state;
  t1c_state_t next_state;

  // Control fields
  wire counter_run = ctrl[RUN_BIT];
  wire idle_halt = ctrl[IDLE_BIT];
  wire [1:0] ext_source_sel = ctrl[ESRC_LSB+1:ESRC_LSB];
  wire gate_accum_en = ctrl[GATE_BIT];
  wire [1:0] prescale_sel = ctrl[PRE_LSB+1:PRE_LSB];
  // Sync select bit is stored and read back only
  wire source_sel = ctrl[SRC_BIT];

  // Bus decode
  wire wr_ctrl = wr_i && (addr_i == CTRL_IDX);
  wire wr_count = wr_i && (addr_i == COUNT_IDX);
  wire rd_ctrl = rd_i && (addr_i == CTRL_IDX);
  wire rd_count = rd_i && (addr_i == COUNT_IDX);

  // Outside sources: two stages each, then an edge history stage
  wire [NUM_SRC-1:0] src_raw;
  wire [NUM_SRC-1:0] src_sync;
  wire [NUM_SRC-1:0] src_prev;
  wire [NUM_SRC-1:0] src_rise;
  assign src_raw[SRC_SECONDARY_OSC] = secondary_osc_i;
  assign src_raw[SRC_PIN] = ext_count_pin_i;
  assign src_raw[SRC_LOW_POWER_RC_OSC] = low_power_rc_osc_i;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_sync
      logic meta;
      logic held;
      logic prev;
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          meta <= 1'b0;
          held <= 1'b0;
          prev <= 1'b0;
        end else if (ce_i) begin
          meta <= src_raw[g];
          held <= meta;
          prev <= held;
        end
      end
      assign src_sync[g] = held;
      assign src_prev[g] = prev;
      assign src_rise[g] = held && !prev;
    end
  endgenerate

  // Extended source decode; code 11 yields no edges at all
  wire ext_tick =
    (ext_source_sel == ESRC_SECONDARY_OSC) ? src_rise[SRC_SECONDARY_OSC] :
    (ext_source_sel == ESRC_PIN) ? src_rise[SRC_PIN] :
    (ext_source_sel == ESRC_LOW_POWER_RC_OSC) ? src_rise[SRC_LOW_POWER_RC_OSC] :
    1'b0;

  // Gate follows the count pin; only meaningful on the internal clock
  wire gate_lvl = src_sync[SRC_PIN];
  wire gate_mode = gate_accum_en && !source_sel;

  // mclk is the Fosc/2 instruction clock, so it ticks every cycle
  wire int_tick = gate_mode ? gate_lvl : 1'b1;
  wire raw_tick = source_sel ? ext_tick : int_tick;

  // Prescaler terminal value
  wire [7:0] pre_last =
    (prescale_sel == PRE_SEL_256) ? PRE_LAST_256 :
    (prescale_sel == PRE_SEL_64) ? PRE_LAST_64 :
    (prescale_sel == PRE_SEL_8) ? PRE_LAST_8 :
    PRE_LAST_1;

  // Clearing the run bit stops counting at once, not one cycle late
  wire run_ok = (state == ST_RUN) && counter_run;
  wire pre_adv = run_ok && raw_tick;
  wire pre_tick = pre_adv && (pre_cnt == pre_last);
  // Rewriting control while running restarts the prescale phase
  wire pre_clr = !counter_run || wr_ctrl;

  wire [7:0] next_pre_cnt =
    pre_clr ? PRE_RESET :
    pre_tick ? PRE_RESET :
    pre_adv ? 8'(pre_cnt + 8'h01) :
    pre_cnt;

  wire [15:0] next_count =
    wr_count ? wdata_i :
    pre_tick ? 16'(count + 16'h0001) :
    count;

  // Run state: stopped, running, or halted by idle request
  always_comb begin
    case (state)
      ST_STOP: begin
        next_state = counter_run ? ST_RUN : ST_STOP;
      end
      ST_RUN: begin
        if (!counter_run) begin
          next_state = ST_STOP;
        end else if (idle_i && idle_halt) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (!counter_run) begin
          next_state = ST_STOP;
        end else if (!(idle_i && idle_halt)) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_STOP;
      end
    endcase
  end

  // State follows control one cycle late; counting starts after that
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_STOP;
      pre_cnt <= PRE_RESET;
      count <= COUNT_RESET;
    end else if (ce_i) begin
      state <= next_state;
      pre_cnt <= next_pre_cnt;
      count <= next_count;
    end
  end

  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (ce_i && wr_ctrl) begin
      ctrl <= wdata_i & CTRL_MASK;
    end
  end

  wire [15:0] rd_mux =
    rd_ctrl ? ctrl :
    rd_count ? count :
    16'h0000;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= rd_mux;
    end
  end

  assign count_o = count;
  assign running_o = run_ok;

  ext_ignored_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!source_sel && !gate_accum_en) |-> raw_tick)
    else $error("internal clock did not tick every cycle");

  ext_decode_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (source_sel && ext_source_sel == ESRC_PIN)
      |-> (raw_tick == (src_sync[SRC_PIN] && !src_prev[SRC_PIN])))
    else $error("pin source edge not followed");

  ext_reserved_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (source_sel && ext_source_sel == ESRC_RSVD) |-> !raw_tick)
    else $error("reserved source produced ticks");

  gate_hold_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && run_ok && !source_sel && gate_accum_en && !gate_lvl
      && !wr_count) |=> (count == $past(count)))
    else $error("count moved with gate low");

  gate_ignored_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && run_ok && source_sel && gate_accum_en && ext_tick
      && prescale_sel == PRE_SEL_1 && !wr_count && !wr_ctrl)
      |=> (count == 16'($past(count) + 16'h0001)))
    else $error("gate bit stopped extended counting");

  pre_eight_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (pre_tick && prescale_sel == PRE_SEL_8) |-> (pre_cnt == 8'h07))
    else $error("divide by 8 terminal wrong");

  pre_early_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (prescale_sel == PRE_SEL_256 && pre_cnt != 8'hff) |-> !pre_tick)
    else $error("divide by 256 ticked early");

  low_power_rc_osc_select_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (source_sel && ext_source_sel == ESRC_LOW_POWER_RC_OSC)
      |-> (raw_tick == src_rise[SRC_LOW_POWER_RC_OSC]))
    else $error("oscillator source not followed");

  stop_hold_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!counter_run && !wr_count) |=> $stable(count))
    else $error("count moved while stopped");

  run_start_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && state == ST_STOP && counter_run && !idle_i)
      |=> (state == ST_RUN))
    else $error("run bit did not start timer");

  ce_freeze_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !ce_i |=> ($stable(count) && $stable(ctrl) && $stable(state)
      && $stable(rdata_o)))
    else $error("state moved with clock enable low");

  ctrl_mask_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ctrl & ~CTRL_MASK) == 16'h0000)
    else $error("reserved control bit stored");

  rd_quiet_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && !rd_i) |=> (rdata_o == 16'h0000))
    else $error("read data stood without a read");

  count_load_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && wr_count) |=> (count == $past(wdata_i)))
    else $error("count write lost");

  secondary_osc_select_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (source_sel && ext_source_sel == ESRC_SECONDARY_OSC)
      |-> (raw_tick == src_rise[SRC_SECONDARY_OSC]))
    else $error("secondary source not followed");

  gate_only_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    source_sel |-> !gate_mode)
    else $error("gating active on extended source");

  gate_count_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && run_ok && !source_sel && gate_accum_en && gate_lvl
      && prescale_sel == PRE_SEL_1 && !wr_count && !wr_ctrl)
      |=> (count == 16'($past(count) + 16'h0001)))
    else $error("count held with gate high");

  gate_off_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && run_ok && !source_sel && !gate_accum_en && !gate_lvl
      && prescale_sel == PRE_SEL_1 && !wr_count && !wr_ctrl)
      |=> (count == 16'($past(count) + 16'h0001)))
    else $error("gating applied while disabled");

  pre_sixtyfour_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (pre_tick && prescale_sel == PRE_SEL_64) |-> (pre_cnt == 8'h3f))
    else $error("divide by 64 terminal wrong");

  pre_restart_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && wr_ctrl) |=> (pre_cnt == PRE_RESET))
    else $error("control write kept prescale phase");

  idle_freeze_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state == ST_IDLE && !wr_count) |=> $stable(count))
    else $error("count moved while idle halted");

  stop_state_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && !counter_run) |=> (state == ST_STOP))
    else $error("run bit clear did not stop timer");

endmodule : t1c_timer

// ### tb.sv
// Self-checking testbench for the timer control block
`timescale 1ns/1ns
module tb;
  import t1c_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic idle_i = 1'b0;
  logic [2:0] osc = 3'h0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] rdata_o;
  logic [DATA_W-1:0] count_o;
  logic running_o;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] c;
  int num_errors = 0;
  int compares = 0;
  t1c_timer u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .idle_i(idle_i), .ext_count_pin_i(osc[SRC_PIN]),
    .low_power_rc_osc_i(osc[SRC_LOW_POWER_RC_OSC]), .secondary_osc_i(osc[SRC_SECONDARY_OSC]),
    .rdata_o(rdata_o), .count_o(count_o), .running_o(running_o));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    d = rdata_o;
  endtask : rd_reg
  // Count gained between two reads exactly n cycles apart (n >= 3)
  task automatic gain(input int n, output logic [15:0] d);
    logic [15:0] a;
    logic [15:0] b;
    rd_reg(COUNT_IDX, a);
    repeat (n - 3) @(posedge mclk_i);
    rd_reg(COUNT_IDX, b);
    d = b - a;
  endtask : gain
  function automatic logic [15:0] run_w(input logic [15:0] f);
    return 16'h8000 | f;
  endfunction : run_w
  function automatic int pre_div(input int p);
    return (p == 3) ? 256 : (p == 2) ? 64 : (p == 1) ? 8 : 1;
  endfunction : pre_div
  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge mclk_i);
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(40388));
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_reg(CTRL_IDX, v);
    chk(v, CTRL_RESET);
    rd_reg(COUNT_IDX, v);
    chk(v, COUNT_RESET);
    rd_reg(2'h3, v);
    chk(v, 16'h0000);
    // Random stopped settings read back with reserved bits dropped
    for (int i = 0; i < 8; i++) begin
      c = 16'($urandom()) & 16'h7fff;
      wr_reg(CTRL_IDX, c);
      rd_reg(CTRL_IDX, v);
      chk(v, c & CTRL_MASK);
    end
    // Internal clock rate per prescale code; extended field disregarded
    for (int p = 0; p < 4; p++) begin
      wr_reg(CTRL_IDX, run_w(16'((p % 3) << ESRC_LSB | p << PRE_LSB)));
      repeat (4) @(posedge mclk_i);
      gain(3 * pre_div(p), v);
      chk(v, 16'h0003);
    end
    chk({15'h0, running_o}, 16'h0001);
    wr_reg(CTRL_IDX, 16'h0000);
    repeat (3) @(posedge mclk_i);
    chk({15'h0, running_o}, 16'h0000);
    gain(20, v);
    chk(v, 16'h0000);
    // Gated accumulation follows the count pin
    wr_reg(CTRL_IDX, run_w(16'h0001 << GATE_BIT));
    repeat (4) @(posedge mclk_i);
    gain(10, v);
    chk(v, 16'h0000);
    osc[SRC_PIN] <= 1'b1;
    repeat (4) @(posedge mclk_i);
    gain(10, v);
    chk(v, 16'h000a);
    osc[SRC_PIN] <= 1'b0;
    // Each extended source, gate bit set but ignored; input j pulses j+1
    for (int s = 0; s < 4; s++) begin
      wr_reg(COUNT_IDX, 16'h0000);
      c = 16'(s << ESRC_LSB | 1 << GATE_BIT | 1 << SRC_BIT);
      wr_reg(CTRL_IDX, run_w(c));
      for (int j = 0; j < 3; j++) begin
        for (int k = 0; k <= j; k++) begin
          osc[j] <= 1'b1;
          repeat (4) @(posedge mclk_i);
          osc[j] <= 1'b0;
          repeat (4) @(posedge mclk_i);
        end
      end
      repeat (6) @(posedge mclk_i);
      rd_reg(COUNT_IDX, v);
      chk(v, (s == 3) ? 16'h0000 : 16'(s + 1));
    end
    // Idle halt freezes the count
    wr_reg(CTRL_IDX, run_w(16'h0001 << IDLE_BIT));
    idle_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk({15'h0, running_o}, 16'h0000);
    gain(12, v);
    chk(v, 16'h0000);
    idle_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    gain(12, v);
    chk(v, 16'h000c);
    // Clock enable low freezes the count, then counting resumes
    ce_i <= 1'b0;
    @(posedge mclk_i);
    c = count_o;
    repeat (8) @(posedge mclk_i);
    chk(count_o, c);
    ce_i <= 1'b1;
    gain(5, v);
    chk(v, 16'h0005);
    give_verdict();
  end
endmodule : tb
